// *** dv/flash_self_rewrite_control_test.sv ***
// Self-checking bench for the flash self-rewrite sequencer.
// Assumes the design's own assertions guard the cycle-level timing; this bench
// drives software strobes as one-cycle pulses.
`timescale 1ns/1ps
module flash_self_rewrite_control_test;
    import flash_self_rewrite_pkg::*;

    // Short erase counts keep the run brief
    localparam int SEC_CYC = 20;
    localparam int BLK_CYC = 30;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    // Clock enable drops only while idle, never during an operation
    logic ce = 1'b1;
    logic self_rewrite_enable = 1'b1;
    logic wrDataLow = 1'b0;
    logic wrDataHigh = 1'b0;
    logic sectorEraseReq = 1'b0;
    logic blockEraseReq = 1'b0;
    logic wrProtect = 1'b0;
    logic [BYTE_W-1:0] wrByte = 8'h00;
    logic [SEG_W-1:0] seg = 4'h0;
    logic [ADDR_W-1:0] addr = 16'h0000;
    flash_cmd_t flashCmd;
    flash_status_t status;
    logic cpuHold;
    int badCount = 0;
    int nChecks = 0;
    int n;
    logic [15:0] blkAddr [3] = '{16'h0000, 16'h07FF, 16'h0800};

    always #20 clk = ~clk;

    flash_self_rewrite_control #(
        .SECTOR_ERASE_CYCLES(SEC_CYC),
        .BLOCK_ERASE_CYCLES(BLK_CYC)
    ) dut (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .self_rewrite_enable(self_rewrite_enable),
        .wrDataLow(wrDataLow),
        .wrDataHigh(wrDataHigh),
        .wrByte(wrByte),
        .progSeg(seg),
        .progAddr(addr),
        .sectorEraseReq(sectorEraseReq),
        .blockEraseReq(blockEraseReq),
        .eraseSeg(seg),
        .eraseAddr(addr),
        .wrProtect(wrProtect),
        .protectByte(wrByte[3:0]),
        .flashCmd(flashCmd),
        .flash_status_reg(status),
        .cpuHold(cpuHold)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            badCount++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // k: 0 low data, 1 high data, 2 sector erase, 3 block erase, 4 protect
    task automatic req(input int k, input logic [7:0] b, input logic [3:0] s,
                       input logic [15:0] a);
        @(posedge clk);
        wrByte <= b;
        seg <= s;
        addr <= a;
        wrDataLow <= (k == 0);
        wrDataHigh <= (k == 1);
        sectorEraseReq <= (k == 2);
        blockEraseReq <= (k == 3);
        wrProtect <= (k == 4);
        @(posedge clk);
        {wrDataLow, wrDataHigh, sectorEraseReq, blockEraseReq, wrProtect} <= 5'h0;
        #1;
    endtask

    task automatic waitIdle(input int minCyc);
        n = 0;
        while ((status.erase_in_progress_flag | status.program_in_progress_flag) !== 1'b0
               && n < 5000)
        begin
            check("cpu hold while busy", cpuHold, 0);
            @(posedge clk);
            #1;
            n++;
        end
        check("busy cleared in time", n < 5000, 1);
        check("busy long enough", n + 4 >= minCyc, 1);
    endtask

    task automatic printVerdict;
        $display("checks %0d, mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #(40 * 10000);
        badCount++;
        printVerdict();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        req(2, 8'h00, 4'h1, 16'h1234);
        check("target erase start", {flashCmd.start, flashCmd.eraseSector}, 2'b11);
        waitIdle(SEC_CYC);
        req(0, 8'h5A, 4'h1, 16'h1234);
        check("start after low write", flashCmd.start, 0);
        check("status after low write", status, 0);
        req(1, 8'hC3, 4'h1, 16'h1234);
        check("program start", {flashCmd.start, flashCmd.prog}, 2'b11);
        check("program seg", flashCmd.seg, 4'h1);
        check("program data", flashCmd.data, 16'hC35A);
        check("program addr", flashCmd.addr, 16'h1234);
        check("program flag", status.program_in_progress_flag, 1);
        req(2, 8'h00, 4'h2, 16'h0100);
        check("erase while busy refused", {status.rejected, flashCmd.start}, 2'b10);
        req(1, 8'h11, 4'h1, 16'h1236);
        check("program while busy refused", {status.rejected, flashCmd.start}, 2'b10);
        waitIdle(PROG_CYC);
        $display("test program done");
        req(2, 8'h00, 4'h2, 16'h0100);
        check("sector erase start", {flashCmd.start, flashCmd.eraseSector}, 2'b11);
        check("erase flag", status.erase_in_progress_flag, 1);
        req(1, 8'h22, 4'h1, 16'h0000);
        check("program while erasing refused", status.rejected, 1);
        waitIdle(SEC_CYC);
        $display("test sector erase done");
        req(3, 8'h00, 4'h4, 16'h07FF);
        check("unprotected block erase", {flashCmd.start, flashCmd.eraseBlock}, 2'b11);
        waitIdle(BLK_CYC);
        req(4, 8'h08, 4'h0, 16'h0000);
        check("protect bits", status.erase_protect_reg, 4'h8);
        for (int i = 0; i < 3; i++)
        begin
            req(3, 8'h00, 4'h4, blkAddr[i]);
            check("protected block start", flashCmd.start, i == 2);
            check("protected block refusal", status.rejected, i != 2);
            waitIdle(0);
        end
        $display("test protection done");
        ce <= 1'b0;
        req(1, 8'h33, 4'h1, 16'h2000);
        check("no start while frozen", {flashCmd.start, status.rejected}, 2'b00);
        ce <= 1'b1;
        self_rewrite_enable <= 1'b0;
        req(2, 8'h00, 4'h2, 16'h0100);
        check("erase while disabled refused", {status.rejected, flashCmd.start}, 2'b10);
        $display("test freeze and disable done");
        printVerdict();
    end
endmodule // flash_self_rewrite_control_test

// *** hdl/flash_self_rewrite_control.sv ***
// Flash self-rewrite sequencer: one-word program, sector and block erase.
// Assumes software strobes are one-cycle pulses in the clk domain.
`timescale 1ns/1ps
module flash_self_rewrite_control
    import flash_self_rewrite_pkg::*;
#(
    parameter int SECTOR_ERASE_CYCLES = SECTOR_ERASE_CYC,
    parameter int BLOCK_ERASE_CYCLES = BLOCK_ERASE_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Self-rewrite enable
    input wire logic self_rewrite_enable,
    // Data register writes
    input wire logic wrDataLow,
    input wire logic wrDataHigh,
    input wire logic [BYTE_W-1:0] wrByte,
    input wire logic [SEG_W-1:0] progSeg,
    input wire logic [ADDR_W-1:0] progAddr,
    // Erase commands
    input wire logic sectorEraseReq,
    input wire logic blockEraseReq,
    input wire logic [SEG_W-1:0] eraseSeg,
    input wire logic [ADDR_W-1:0] eraseAddr,
    // Protection register write
    input wire logic wrProtect,
    input wire logic [PROT_W-1:0] protectByte,
    // Flash array side
    output flash_cmd_t flashCmd,
    // Status and processor
    output flash_status_t flash_status_reg,
    output logic cpuHold
);

    typedef struct packed {
        op_state_t st;
        logic [BYTE_W-1:0] dataLow;
        flash_cmd_t cmd;
        flash_status_t sts;
        logic hold;
    } ctrl_state_t;

    ctrl_state_t state_ff;
    ctrl_state_t nxt_state;
    logic opDone;
    logic busy;
    logic protHit;
    logic [CNT_W-1:0] loadCount;

    assign busy = state_ff.sts.erase_in_progress_flag | state_ff.sts.program_in_progress_flag;
    // Any protect bit ever written to 1 guards the low window of segment 4 against block erase
    assign protHit = (|state_ff.sts.erase_protect_reg) && (eraseSeg == PROT_SEG)
        && (eraseAddr <= PROT_LAST);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.cmd.start = 1'b0;
        nxt_state.sts.rejected = 1'b0;
        nxt_state.hold = 1'b0;
        loadCount = CNT_W'(PROG_CYC);
        // Protect bits are sticky until reset
        if (wrProtect)
            nxt_state.sts.erase_protect_reg = state_ff.sts.erase_protect_reg | protectByte;
        if (wrDataLow)
            nxt_state.dataLow = wrByte;
        case (state_ff.st)
            ST_IDLE:
            begin
                if (self_rewrite_enable && !busy)
                begin
                    if (wrDataHigh)
                    begin
                        nxt_state.st = ST_PROG;
                        nxt_state.cmd.start = 1'b1;
                        nxt_state.cmd.prog = 1'b1;
                        nxt_state.cmd.eraseSector = 1'b0;
                        nxt_state.cmd.eraseBlock = 1'b0;
                        nxt_state.cmd.seg = progSeg;
                        nxt_state.cmd.addr = progAddr;
                        nxt_state.cmd.data = {wrByte, state_ff.dataLow};
                        nxt_state.sts.program_in_progress_flag = 1'b1;
                    end
                    else if (blockEraseReq && protHit)
                    begin
                        nxt_state.sts.rejected = 1'b1;
                    end
                    else if (blockEraseReq || sectorEraseReq)
                    begin
                        nxt_state.st = ST_ERASE;
                        nxt_state.cmd.start = 1'b1;
                        nxt_state.cmd.prog = 1'b0;
                        nxt_state.cmd.eraseBlock = blockEraseReq;
                        nxt_state.cmd.eraseSector = !blockEraseReq;
                        nxt_state.cmd.seg = eraseSeg;
                        nxt_state.cmd.addr = eraseAddr;
                        nxt_state.sts.erase_in_progress_flag = 1'b1;
                    end
                end
                else if (wrDataHigh || blockEraseReq || sectorEraseReq)
                begin
                    // Busy or not enabled: the request is dropped
                    nxt_state.sts.rejected = 1'b1;
                end
            end
            ST_PROG, ST_ERASE:
            begin
                if (wrDataHigh || blockEraseReq || sectorEraseReq)
                    nxt_state.sts.rejected = 1'b1;
                if (opDone)
                begin
                    nxt_state.st = ST_IDLE;
                    nxt_state.cmd.prog = 1'b0;
                    nxt_state.cmd.eraseSector = 1'b0;
                    nxt_state.cmd.eraseBlock = 1'b0;
                    nxt_state.sts.erase_in_progress_flag = 1'b0;
                    nxt_state.sts.program_in_progress_flag = 1'b0;
                end
            end
            default:
            begin
                nxt_state.st = ST_IDLE;
            end
        endcase
        if (state_ff.cmd.eraseBlock)
            loadCount = CNT_W'(BLOCK_ERASE_CYCLES);
        else if (state_ff.cmd.eraseSector)
            loadCount = CNT_W'(SECTOR_ERASE_CYCLES);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff <= '0;
            state_ff.st <= ST_IDLE;
            state_ff.dataLow <= DATA_LOW_RST;
            state_ff.sts.erase_protect_reg <= PROT_RST;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
        end
    end

    // Timer is loaded from the registered command, one cycle after the start pulse
    op_timer u_op_timer (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .start(state_ff.cmd.start),
        .loadCount(loadCount),
        .done(opDone)
    );

    assign flashCmd = state_ff.cmd;
    assign flash_status_reg = state_ff.sts;
    assign cpuHold = state_ff.hold;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_HIGH_STARTS_PROG: assert property (
        ce && wrDataHigh && self_rewrite_enable && !busy && state_ff.st == ST_IDLE
        |=> flashCmd.start && flashCmd.prog && flash_status_reg.program_in_progress_flag
        && flashCmd.data[BYTE_W-1:0] == $past(state_ff.dataLow))
        else $error("high data write did not start a program");

    AST_LOW_NO_START: assert property (
        ce && wrDataLow && !wrDataHigh && !blockEraseReq && !sectorEraseReq
        |=> !flashCmd.start)
        else $error("low data write started an operation");

    AST_BUSY_IGNORE: assert property (
        ce && busy && (wrDataHigh || blockEraseReq || sectorEraseReq)
        |=> !flashCmd.start && flash_status_reg.rejected)
        else $error("request accepted while busy");

    AST_NO_STALL: assert property (
        busy |-> !cpuHold)
        else $error("processor held during flash operation");

    // Only meaningful while idle: a running erase keeps its own flag up
    AST_PROTECT_BLOCK: assert property (
        ce && blockEraseReq && !wrDataHigh && protHit && !busy
        |=> !flash_status_reg.erase_in_progress_flag ##0 !flashCmd.start)
        else $error("protected block erase was accepted");

    AST_PROTECT_STICKY: assert property (
        |flash_status_reg.erase_protect_reg |=> |flash_status_reg.erase_protect_reg)
        else $error("protect bit cleared without reset");

    AST_ERASE_FLAG_SET: assert property (
        flashCmd.start && (flashCmd.eraseSector || flashCmd.eraseBlock)
        |-> flash_status_reg.erase_in_progress_flag && !flash_status_reg.program_in_progress_flag)
        else $error("erase start without erase flag");

    AST_FLAG_CLEAR: assert property (
        ce && opDone |=> !flash_status_reg.erase_in_progress_flag
        && !flash_status_reg.program_in_progress_flag)
        else $error("busy flag not cleared at completion");

    AST_DISABLED_REJECT: assert property (
        ce && !self_rewrite_enable && (wrDataHigh || blockEraseReq || sectorEraseReq)
        |=> !flashCmd.start && flash_status_reg.rejected)
        else $error("request accepted while self-rewrite disabled");

    // A held start would reload the timer and stretch the operation
    AST_START_PULSE: assert property (
        ce && flashCmd.start |=> !flashCmd.start)
        else $error("start held longer than one cycle");

    AST_ONE_OP: assert property (
        !(flash_status_reg.erase_in_progress_flag && flash_status_reg.program_in_progress_flag))
        else $error("erase and program flags both set");

    // Program completion lies beyond a short delay range, so cover the end itself
    COV_PROG: cover property (flashCmd.prog && opDone);
    COV_SECTOR: cover property (flashCmd.start && flashCmd.eraseSector);
    COV_PROT_REJECT: cover property (ce && blockEraseReq && protHit && !busy);
    COV_BUSY_REJECT: cover property (ce && busy && wrDataHigh);
    COV_DISABLED_REJECT: cover property (ce && !self_rewrite_enable && sectorEraseReq);

endmodule // flash_self_rewrite_control

// *** hdl/flash_self_rewrite_pkg.sv ***
// Constants and carrier types for the flash self-rewrite controller.
// Assumes a 25 MHz system clock taken from the fast oscillator.
// Notes on behaviour
// - Writing high data register starts one-word program
// - Requests ignored while either busy flag set
// - Processor keeps running during flash operations
// - Protect bit set blocks low segment-4 block erase
package flash_self_rewrite_pkg;

    localparam int CLK_PERIOD_NS = 40;
    // Operation durations are least times: rounded up to whole cycles
    localparam int PROG_TIME_NS = 40000;
    localparam int SECTOR_ERASE_TIME_MS = 50;
    localparam int BLOCK_ERASE_TIME_MS = 100;
    localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SECTOR_ERASE_CYC =
        (SECTOR_ERASE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLOCK_ERASE_CYC =
        (BLOCK_ERASE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 24;
    localparam int SEG_W = 4;
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    localparam int PROT_W = 4;

    // Block erase protection window in segment 4
    localparam logic [SEG_W-1:0] PROT_SEG = 4'h4;
    localparam logic [ADDR_W-1:0] PROT_LAST = 16'h07FF;

    localparam logic [BYTE_W-1:0] DATA_LOW_RST = 8'h00;
    localparam logic [PROT_W-1:0] PROT_RST = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_ERASE = 2'b10
    } op_state_t;

    // Command towards the flash array
    typedef struct packed {
        logic start;
        logic prog;
        logic eraseSector;
        logic eraseBlock;
        logic [SEG_W-1:0] seg;
        logic [ADDR_W-1:0] addr;
        logic [2*BYTE_W-1:0] data;
    } flash_cmd_t;

    // Software-visible status
    typedef struct packed {
        logic erase_in_progress_flag;
        logic program_in_progress_flag;
        logic rejected;
        logic [PROT_W-1:0] erase_protect_reg;
    } flash_status_t;

endpackage

// *** hdl/op_timer.sv ***
// Down-counter that times one flash operation.
// Assumes start is a one-cycle pulse issued only while idle.
`timescale 1ns/1ps
module op_timer
    import flash_self_rewrite_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic start,
    input wire logic [CNT_W-1:0] loadCount,
    output logic done
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic busy;
        logic done;
    } timer_state_t;

    timer_state_t state_ff;
    timer_state_t nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.done = 1'b0;
        if (start)
        begin
            nxt_state.cnt = loadCount;
            nxt_state.busy = 1'b1;
        end
        else if (state_ff.busy)
        begin
            if (state_ff.cnt <= 24'h00_0001)
            begin
                nxt_state.busy = 1'b0;
                nxt_state.done = 1'b1;
            end
            else
            begin
                nxt_state.cnt = state_ff.cnt - 24'h00_0001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_ff <= '0;
        else if (ce)
            state_ff <= nxt_state;
    end

    assign done = state_ff.done;

endmodule // op_timer
